// ===== shared/fpe_pkg.sv
// constants, types and state names of the flash program/wipe controller
// assumes an avalon-mm master whose word address equals the cpu byte address
//
// Behaviour
// [R01] wiped cells read one, programming clears bits
// [R02] 64-byte wipe pages, 32-byte program rows
// [R03] decode array, control, protect-start and vectors
// [R04] high voltage only after proper select sequence
// [R05] whole-array select picks full or page wipe
// [R06] wipe and program selects never both set
// [R07] page wipe: select, read protect, write page
// [R08] page wipe waits and high-voltage timing by software
// [R09] wipe page is 64 aligned bytes, vectors included
// [R10] software picks 4 ms wipe for endurance
// [R11] whole wipe sequence and waits by software
// [R12] whole wipe refused unless protect-start all ones
// [R13] monitor mode selects whole wipe via protect-start; no monitor mode here, whole wipe is control bit 2 only
// [R14] one aligned row per program cycle, else fail
// [R15] software programs only erased bytes
// [R16] program select latches array writes for programming
// [R17] program sequence and byte waits by software
// [R18] byte write gaps within byte program maximum
// [R19] cumulative high-voltage time kept by software
// [R20] sequences run from outside the array
// [R21] software disables interrupts during sequences
// [R22] software targets real array locations only
// [R23] protected address blocks high-voltage enable
// [R24] protect bits form start address bits 13:6
// [R25] control bits 0..3, upper zero, reset clear

package fpe_pkg;

  localparam int          ADDR_W        = 16;
  localparam int          CELL_AW       = 14;
  localparam int          DATA_W        = 32;
  localparam int          PAGE_LSB      = 6;
  localparam int          ROW_LSB       = 5;

  // word indices on the bus; each one equals the cpu byte address
  localparam logic [15:0] USER_LO_IDX   = 16'hC000;
  localparam logic [15:0] USER_HI_IDX   = 16'hFDFF;
  localparam logic [15:0] CTRL_IDX      = 16'hFE08;
  localparam logic [15:0] STAT_IDX      = 16'hFE09;
  localparam logic [15:0] PROT_IDX      = 16'hFF7E;
  localparam logic [15:0] VECT_LO_IDX   = 16'hFFD4;

  localparam logic [7:0]  PROT_NONE     = 8'hFF;
  localparam logic [7:0]  CELL_WIPED    = 8'hFF;
  localparam logic [1:0]  PROT_TOP_BITS = 2'b11;

  // control register field positions
  localparam int          CTRL_PROG_BIT = 0;
  localparam int          CTRL_WIPE_BIT = 1;
  localparam int          CTRL_ALL_BIT  = 2;
  localparam int          CTRL_HV_BIT   = 3;

  // status register field positions
  localparam int          STAT_FAIL_BIT = 0;
  localparam int          STAT_REF_BIT  = 1;
  localparam int          STAT_BUSY_BIT = 2;
  localparam int          STAT_SEQ_LSB  = 4;

  typedef struct packed {
    logic hv;
    logic whole;
    logic wipe;
    logic prog;
  } fpe_ctrl_t;

  localparam fpe_ctrl_t   CTRL_RESET    = 4'h0;

  typedef struct packed {
    logic [CELL_AW-1:0] addr;
    logic [7:0]         data;
  } fpe_latch_t;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_CHECKED,
    SEQ_LATCHED,
    SEQ_HIGH
  } fpe_seq_t;

endpackage

// ===== design/fpe_cell_array.sv
// byte-wide cell store with a one-byte-per-cycle wipe engine
// assumes program and wipe are never requested in the same cycle

`timescale 1ns/1ps

module fpe_cell_array #(
  parameter int AW = 14,
  parameter int DW = 8
) (
  input  wire logic          clk_in,          // system clock
  input  wire logic          reset_n_in,      // async reset, low
  input  wire logic [AW-1:0] rd_addr_in,      // read address
  output logic      [DW-1:0] rd_data_out,     // read data, next cycle
  input  wire logic          prog_en_in,      // program one byte
  input  wire logic [AW-1:0] prog_addr_in,    // byte to program
  input  wire logic [DW-1:0] prog_data_in,    // zeros clear bits
  input  wire logic          wipe_go_in,      // start a wipe
  input  wire logic          wipe_all_in,     // whole store when high
  input  wire logic [AW-7:0] wipe_page_in,    // page to wipe
  input  wire logic [AW-1:0] prot_idx_in,     // protect byte location
  output logic      [DW-1:0] prot_bits_out,   // protect byte copy
  output logic               busy_out         // wipe in progress
);

  logic [DW-1:0] mem [0:(2**AW)-1];
  logic [AW-1:0] cnt_r;
  logic [AW-1:0] end_r;

  // cells leave the factory wiped
  initial
  begin
    for (int i = 0; i < 2**AW; i++)
      mem[i] = {DW{1'b1}};
  end

  // programming can only pull ones to zero
  always_ff @(posedge clk_in)
  begin
    rd_data_out <= mem[rd_addr_in];
    if (prog_en_in)
      mem[prog_addr_in] <= mem[prog_addr_in] & prog_data_in; // [R01]
    else if (busy_out)
      mem[cnt_r] <= {DW{1'b1}}; // [R01]
  end

  // wipe walks one byte per clock; far shorter than any wipe hold
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_r         <= '0;
      end_r         <= '0;
      busy_out      <= 1'b0;
      prot_bits_out <= {DW{1'b1}};
    end
    else
    begin
      prot_bits_out <= mem[prot_idx_in];
      if (wipe_go_in)
      begin
        busy_out <= 1'b1;
        cnt_r    <= wipe_all_in ? '0 : {wipe_page_in, 6'h00};            // [R09]
        end_r    <= wipe_all_in ? {AW{1'b1}} : {wipe_page_in, 6'h3F};    // [R02]
      end
      else if (busy_out)
      begin
        cnt_r    <= cnt_r + 1'b1;
        busy_out <= (cnt_r != end_r);
      end
    end
  end

endmodule // fpe_cell_array

// ===== design/fpe_flash_ctrl.sv
// program/wipe sequencer with its avalon-mm register and array port
// assumes the cpu keeps every documented wait; the block checks order only
//
// Chosen here: the Avalon-MM interface to the registers.

`timescale 1ns/1ps

module fpe_flash_ctrl (
  input  wire logic        mclk_in,              // 125 mhz system clock
  input  wire logic        reset_n_in,           // async reset, low
  input  wire logic [15:0] avs_address_in,       // word index
  input  wire logic        avs_read_in,          // read request
  input  wire logic        avs_write_in,         // write request
  input  wire logic [31:0] avs_writedata_in,     // write data
  output logic      [31:0] avs_readdata_out,     // read data
  output logic             avs_waitrequest_out,  // low when answered
  output logic             high_voltage_on_out   // charge pump enable
);

  localparam int CW = fpe_pkg::CELL_AW;

  // address is a user byte, the protect byte or a vector
  function automatic logic is_array(input logic [15:0] a);
    is_array = (a >= fpe_pkg::USER_LO_IDX && a <= fpe_pkg::USER_HI_IDX) // [R03]
            || (a == fpe_pkg::PROT_IDX)
            || (a >= fpe_pkg::VECT_LO_IDX);
  endfunction

  // protected from the start address up to the top
  function automatic logic is_protected(input logic [15:0] a,
                                        input logic [7:0]  bits);
    is_protected = (bits != fpe_pkg::PROT_NONE)
                && (a >= {fpe_pkg::PROT_TOP_BITS, bits, 6'h00}); // [R24]
  endfunction

  fpe_pkg::fpe_ctrl_t  ctrl_r;
  fpe_pkg::fpe_ctrl_t  ctrl_nxt;
  fpe_pkg::fpe_ctrl_t  ctrl_w;
  fpe_pkg::fpe_seq_t   seq_r;
  fpe_pkg::fpe_seq_t   seq_nxt;
  fpe_pkg::fpe_latch_t lat_r;
  fpe_pkg::fpe_latch_t lat_nxt;

  logic        wait_r;
  logic        phase_r;
  logic [15:0] sel_addr_r;
  logic [15:0] sel_addr_nxt;
  logic        lat_go_r;
  logic        lat_go_nxt;
  logic        row_fail_r;
  logic        row_fail_nxt;
  logic        refused_r;
  logic        refused_nxt;
  logic        wipe_go_r;
  logic        wipe_go_nxt;
  logic        wipe_all_r;
  logic [31:0] rdata_nxt;

  wire  [7:0]  cell_q;
  wire  [7:0]  prot_bits;
  wire         wipe_busy;

  // bus decode
  wire  [15:0] addr      = avs_address_in;
  wire         acc_rd    = avs_read_in & ~wait_r;
  wire         acc_wr    = avs_write_in & ~wait_r;
  wire         hit_arr   = is_array(addr);
  wire         hit_ctrl  = (addr == fpe_pkg::CTRL_IDX);
  wire         hit_stat  = (addr == fpe_pkg::STAT_IDX);
  wire         hit_prot  = (addr == fpe_pkg::PROT_IDX);
  wire         wr_ctrl   = acc_wr & hit_ctrl;
  wire         wr_arr    = acc_wr & hit_arr;
  wire         rd_prot   = acc_rd & hit_prot;

  // requested control value with the select interlock
  wire         both_req  = ctrl_w.prog & ctrl_w.wipe;
  wire         new_prog  = both_req ? ctrl_r.prog : ctrl_w.prog; // [R06]
  wire         new_wipe  = both_req ? ctrl_r.wipe : ctrl_w.wipe; // [R06]
  wire         any_sel   = new_prog | new_wipe;

  // a whole wipe needs every block open, else the selected address
  wire         whole_blk = new_wipe & ctrl_w.whole
                         & (prot_bits != fpe_pkg::PROT_NONE);         // [R12]
  wire         addr_blk  = is_protected(sel_addr_r, prot_bits);       // [R23]
  wire         hv_ok     = any_sel & (seq_r == fpe_pkg::SEQ_LATCHED)
                         & ~whole_blk & ~addr_blk;                    // [R04]
  wire         hv_rise   = wr_ctrl & ctrl_w.hv & ~ctrl_r.hv & hv_ok;

  // program writes must stay inside the latched row
  wire         same_row  = (addr[15:fpe_pkg::ROW_LSB]
                         == sel_addr_r[15:fpe_pkg::ROW_LSB]);         // [R14]
  wire         prog_wr   = wr_arr & ctrl_r.prog & ctrl_r.hv
                         & (seq_r == fpe_pkg::SEQ_HIGH);
  wire         prog_ok   = prog_wr & same_row & ~row_fail_r;

  // status word: fail flag, refusal, wipe engine, sequence step
  wire  [7:0]  stat_byte = {1'b0, seq_r, 1'b0, wipe_busy,
                            refused_r, row_fail_r};

  assign ctrl_w = avs_writedata_in[3:0];

  // register next values and sequence steps
  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    seq_nxt      = seq_r;
    sel_addr_nxt = sel_addr_r;
    row_fail_nxt = row_fail_r;
    refused_nxt  = refused_r;
    wipe_go_nxt  = 1'b0;
    lat_nxt      = lat_r;
    lat_go_nxt   = 1'b0;

    if (wr_ctrl)
    begin
      ctrl_nxt.prog  = new_prog;
      ctrl_nxt.wipe  = new_wipe;
      ctrl_nxt.whole = ctrl_w.whole;                     // [R05]
      ctrl_nxt.hv    = ctrl_w.hv & (ctrl_r.hv | hv_ok);  // [R04]
      if (ctrl_w.hv & ~ctrl_r.hv & ~hv_ok)
        refused_nxt = 1'b1;
      // the wipe itself starts when the pump comes on
      wipe_go_nxt = hv_rise & new_wipe;
    end

    unique case (seq_r)
      fpe_pkg::SEQ_IDLE:
      begin
        if (wr_ctrl & any_sel)
        begin
          seq_nxt      = fpe_pkg::SEQ_ARMED;
          row_fail_nxt = 1'b0;
          refused_nxt  = 1'b0;
        end
      end
      fpe_pkg::SEQ_ARMED:
      begin
        if (rd_prot)
          seq_nxt = fpe_pkg::SEQ_CHECKED;                // [R04]
      end
      fpe_pkg::SEQ_CHECKED:
      begin
        // the protect byte itself serves as selection target too
        if (wr_arr)
        begin
          seq_nxt      = fpe_pkg::SEQ_LATCHED;
          sel_addr_nxt = addr;                           // [R16]
        end
      end
      fpe_pkg::SEQ_LATCHED:
      begin
        if (hv_rise)
          seq_nxt = fpe_pkg::SEQ_HIGH;
      end
      fpe_pkg::SEQ_HIGH:
      begin
        if (prog_wr & ~same_row)
          row_fail_nxt = 1'b1;                           // [R14]
      end
      default:
        seq_nxt = fpe_pkg::SEQ_IDLE;
    endcase

    // dropping every select and the pump ends the sequence
    if (wr_ctrl & ~ctrl_nxt.prog & ~ctrl_nxt.wipe & ~ctrl_nxt.hv)
      seq_nxt = fpe_pkg::SEQ_IDLE;
    else if (wr_ctrl & ~any_sel & ~ctrl_r.hv)
      seq_nxt = fpe_pkg::SEQ_IDLE;

    // array writes under program select are latched, not stored
    if (prog_ok)
    begin
      lat_nxt.addr = addr[CW-1:0];                       // [R16]
      lat_nxt.data = avs_writedata_in[7:0];
      lat_go_nxt   = 1'b1;
    end
  end

  // read data mux, sampled one cycle after the cell read started
  always_comb
  begin
    rdata_nxt = '0;
    if (hit_arr)
      rdata_nxt[7:0] = cell_q;
    else if (hit_ctrl)
      rdata_nxt[3:0] = ctrl_r;                           // [R25]
    else if (hit_stat)
      rdata_nxt[7:0] = stat_byte;
  end

  // bus handshake: two wait cycles, then one answered cycle
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wait_r           <= 1'b1;
      phase_r          <= 1'b0;
      avs_readdata_out <= '0;
    end
    else if (!wait_r)
    begin
      wait_r  <= 1'b1;
      phase_r <= 1'b0;
    end
    else if (avs_read_in | avs_write_in)
    begin
      phase_r <= ~phase_r;
      if (phase_r)
      begin
        wait_r           <= 1'b0;
        avs_readdata_out <= rdata_nxt;
      end
    end
  end

  assign avs_waitrequest_out = wait_r;

  // control and sequence state
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_r     <= fpe_pkg::CTRL_RESET;                 // [R25]
      seq_r      <= fpe_pkg::SEQ_IDLE;
      sel_addr_r <= '0;
      row_fail_r <= 1'b0;
      refused_r  <= 1'b0;
      wipe_go_r  <= 1'b0;
      wipe_all_r <= 1'b0;
      lat_r      <= '0;
      lat_go_r   <= 1'b0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      seq_r      <= seq_nxt;
      sel_addr_r <= sel_addr_nxt;
      row_fail_r <= row_fail_nxt;
      refused_r  <= refused_nxt;
      wipe_go_r  <= wipe_go_nxt;
      wipe_all_r <= ctrl_nxt.whole;                      // [R05]
      lat_r      <= lat_nxt;
      lat_go_r   <= lat_go_nxt;
    end
  end

  // pump output mirrors the stored enable bit
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      high_voltage_on_out <= 1'b0;
    else
      high_voltage_on_out <= ctrl_nxt.hv;                // [R04]
  end

  // cell store; page index is the latched address above bit 5
  fpe_cell_array #(
    .AW (CW),
    .DW (8)
  ) u_cells (
    .clk_in        (mclk_in),
    .reset_n_in    (reset_n_in),
    .rd_addr_in    (addr[CW-1:0]),
    .rd_data_out   (cell_q),
    .prog_en_in    (lat_go_r),
    .prog_addr_in  (lat_r.addr),
    .prog_data_in  (lat_r.data),
    .wipe_go_in    (wipe_go_r),
    .wipe_all_in   (wipe_all_r),
    .wipe_page_in  (sel_addr_r[CW-1:fpe_pkg::PAGE_LSB]), // [R09]
    .prot_idx_in   (fpe_pkg::PROT_IDX[CW-1:0]),
    .prot_bits_out (prot_bits),
    .busy_out      (wipe_busy)
  );

endmodule // fpe_flash_ctrl

// ===== dv/fpe_flash_monitor.sv
// concurrent checks on the sequencer's bus answer and pump enable
// assumes binding to fpe_flash_ctrl; sees only its ports
`timescale 1ns/1ps
module fpe_flash_monitor (
  input wire logic        mclk_in,             // system clock
  input wire logic        reset_n_in,          // async reset, low
  input wire logic [15:0] avs_address_in,      // word index
  input wire logic        avs_read_in,         // read request
  input wire logic        avs_write_in,        // write request
  input wire logic [31:0] avs_writedata_in,    // write data
  input wire logic [31:0] avs_readdata_out,    // read data
  input wire logic        avs_waitrequest_out, // low when answered
  input wire logic        high_voltage_on_out  // pump enable
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // answer and control-register decode
  wire ack       = !avs_waitrequest_out;
  wire ctl_hit   = avs_address_in == fpe_pkg::CTRL_IDX;
  wire ctl_rd    = avs_read_in && ack && ctl_hit;
  wire hv_on_wr  = avs_write_in && ack && ctl_hit && avs_writedata_in[3];
  wire hv_off_wr = avs_write_in && ack && ctl_hit && !avs_writedata_in[3];
  wire low_rd    = avs_read_in && ack && (avs_address_in < fpe_pkg::USER_LO_IDX);
  a_wait_one_cycle: assert property (ack |=> !ack) else $error("answer longer than one cycle");
  a_read_latency: assert property ($rose(avs_read_in) |-> !ack [*2] ##1 ack) else $error("read answer late");
  a_write_latency: assert property ($rose(avs_write_in) |-> !ack [*2] ##1 ack) else $error("write answer late");
  a_idle_no_ack: assert property (!avs_read_in && !avs_write_in |-> !ack) else $error("answer without request");
  a_hv_set_cause: assert property ($rose(high_voltage_on_out) |-> $past(hv_on_wr)) else $error("pump on alone");
  a_hv_clr_cause: assert property ($fell(high_voltage_on_out) |-> $past(hv_off_wr)) else $error("pump off alone");
  a_hv_mirror: assert property (ctl_rd |-> avs_readdata_out[3] == high_voltage_on_out) else $error("hv bit");
  a_ctrl_upper_zero: assert property (ctl_rd |-> avs_readdata_out[31:4] == '0) else $error("upper bits set");
  a_select_interlock: assert property (ctl_rd |-> !(avs_readdata_out[0] && avs_readdata_out[1])) else $error("both");
  a_unmapped_zero: assert property (low_rd |-> avs_readdata_out == '0) else $error("unmapped read not zero");
  // main scenarios reached
  c_pump_on: cover property ($rose(high_voltage_on_out));
  c_ctrl_read: cover property (ctl_rd);
  c_unmapped: cover property (low_rd);
endmodule // fpe_flash_monitor

bind fpe_flash_ctrl fpe_flash_monitor fpe_flash_monitor_i (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .high_voltage_on_out(high_voltage_on_out));

// ===== dv/tb.sv
// self-checking bench of the flash program/wipe sequencer
// assumes fpe_pkg, the design and the bound monitor compile first
`timescale 1ns/1ps
module tb;
  logic        mclk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [15:0] avs_address_in = 16'h0000;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        high_voltage_on_out;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [7:0]  q;
  localparam logic [15:0] CTL = fpe_pkg::CTRL_IDX;
  localparam logic [15:0] PRT = fpe_pkg::PROT_IDX;
  localparam logic [15:0] STS = fpe_pkg::STAT_IDX;

  // 125 mhz clock
  always #4 mclk_in = ~mclk_in;

  fpe_flash_ctrl fpe_flash_ctrl_i (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .high_voltage_on_out(high_voltage_on_out));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one request held until waitrequest is seen low; only the watchdog ends a dead wait
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    avs_address_in   <= a;
    avs_writedata_in <= {24'h00_0000, d};
    avs_read_in      <= !wr;
    avs_write_in     <= wr;
    do
    begin
      @(posedge mclk_in);
    end
    while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out[7:0];
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask

  // pump sampled one cycle after the answering edge
  task automatic hvchk(input logic exp);
    @(posedge mclk_in);
    chk({7'h00, high_voltage_on_out}, {7'h00, exp});
  endtask

  // bench runs the sequences itself, in order, with no interrupts to mask
  task automatic t_reset;
    rd(CTL, 8'h00);
    hvchk(1'b0);
    rd(16'h1234, 8'h00);
    rd(PRT, 8'hFF);
  endtask

  task automatic t_ctrl;
    wr(CTL, 8'h04);
    rd(CTL, 8'h04);
    wr(CTL, 8'hF7);
    rd(CTL, 8'h04);
    wr(CTL, 8'h00);
    wr(CTL, 8'h02);
    wr(CTL, 8'h0A);
    rd(CTL, 8'h02);
    bus(1'b0, STS, 8'h00);
    chk(q & 8'h02, 8'h02);
    wr(CTL, 8'h00);
  endtask

  // waits shrink to bus gaps; hardware checks order only, so timing rules stay software's
  task automatic t_program;
    wr(CTL, 8'h01);
    rd(PRT, 8'hFF);
    wr(16'hC000, 8'h00);
    wr(CTL, 8'h09);
    hvchk(1'b1);
    wr(16'hC000, 8'hA5);
    wr(16'hC01F, 8'h0F);
    wr(CTL, 8'h08);
    wr(CTL, 8'h00);
    hvchk(1'b0);
    rd(16'hC000, 8'hA5);
    rd(16'hC01F, 8'h0F);
    // a byte outside the latched row must fail and stay wiped
    wr(CTL, 8'h01);
    rd(PRT, 8'hFF);
    wr(16'hC040, 8'h00);
    wr(CTL, 8'h09);
    wr(16'hC060, 8'h00);
    bus(1'b0, STS, 8'h00);
    chk(q & 8'h01, 8'h01);
    wr(CTL, 8'h00);
    rd(16'hC060, 8'hFF);
  endtask

  task automatic t_wipe;
    wr(CTL, 8'h02);
    rd(PRT, 8'hFF);
    wr(16'hC010, 8'h55);
    wr(CTL, 8'h0A);
    hvchk(1'b1);
    repeat (80) @(posedge mclk_in);
    wr(CTL, 8'h08);
    wr(CTL, 8'h00);
    rd(16'hC000, 8'hFF);
    rd(16'hC01F, 8'hFF);
  endtask

  task automatic t_protect;
    wr(CTL, 8'h01);
    rd(PRT, 8'hFF);
    wr(PRT, 8'h00);
    wr(CTL, 8'h09);
    wr(PRT, 8'hFE);
    wr(CTL, 8'h00);
    rd(PRT, 8'hFE);
    wr(CTL, 8'h06);
    rd(PRT, 8'hFE);
    wr(16'hC000, 8'h00);
    wr(CTL, 8'h0E);
    hvchk(1'b0);
    wr(CTL, 8'h00);
    wr(CTL, 8'h02);
    rd(PRT, 8'hFE);
    wr(16'hFFE0, 8'h00);
    wr(CTL, 8'h0A);
    hvchk(1'b0);
    wr(CTL, 8'h00);
  endtask

  task automatic print_verdict;
    $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // reset for four cycles, then the scenarios
  initial
  begin
    repeat (4) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_ctrl();
    t_program();
    t_wipe();
    t_protect();
    print_verdict();
  end

  // run needs well under 2000 cycles; cut a hang short
  initial
  begin
    #200000;
    miscompares++;
    print_verdict();
  end
endmodule // tb
